/* rtl/igpe_pkg.sv */
// constants shared by the group 2/3 priority enable block
// assumes a classic wishbone host with 32-bit data and byte addressing, bits 1..0 ignored
//
// Contract
// (RULE1) group 2: each bit's high/low pair decodes to off, level 1, 2 or 3
// (RULE2) group 3: same two-bit decode for each of its eight request bits
// (RULE3) group 2 high and low enables, bit 7: port A7 or voltage detect
// (RULE4) group 2 bit 6: A6 or comparator 0; bit 5: A5 or comparator 1
// (RULE5) group 2 bits 4..1: pins 4..1, port A or D as selected
// (RULE6) group 2 bit 0: port A pin 0 request
// (RULE7) group 3 enables, bit 7 cipher engine, bit 6 multichannel timer
// (RULE8) group 3 bit 5 serial1 receive, bit 4 serial1 transmit
// (RULE9) group 3 bits 3..2: port C pin 3/2 or channel 3/2 shared
// (RULE10) group 3 bits 1..0: port C pins 1 and 0
// (RULE11) select bits 4..1: clear routes port A pin, set routes port D pin
// (RULE12) select bits 7..5 route voltage detect, comparator 0, comparator 1
// (RULE13) second select bits 3..2 route channel 3/2 instead of port C
// (RULE14) present highest-level pending request; disabled never presented
package igpe_pkg;
  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [11:0] IDX_G2_EN_HI  = 12'hfc7;
  localparam logic [11:0] IDX_G2_EN_LO  = 12'hfc8;
  localparam logic [11:0] IDX_G3_EN_HI  = 12'hfca;
  localparam logic [11:0] IDX_G3_EN_LO  = 12'hfcb;
  localparam logic [11:0] IDX_SRC_SEL0  = 12'hfcd;
  localparam logic [11:0] IDX_SRC_SEL1  = 12'hfce;
  localparam logic [11:0] IDX_STATUS    = 12'hfd0;
  // ----------------------------------------------------------------
  // reset values and field layouts
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_ENABLE    = 8'h00;
  localparam logic [7:0]  RST_SELECT    = 8'h00;
  localparam logic [7:0]  SEL1_RW_MASK  = 8'h0c;
  localparam int          STAT_VALID    = 7;
  localparam int          STAT_LVL_LSB  = 5;
  localparam int          NUM_SOURCES   = 16;
  localparam int          GROUP_BITS    = 8;
  // ----------------------------------------------------------------
  // priority level codes {high,low}
  // ----------------------------------------------------------------
  localparam logic [1:0]  LVL_OFF       = 2'h0;
  localparam logic [1:0]  LVL_LOW       = 2'h1;
  localparam logic [1:0]  LVL_NOMINAL   = 2'h2;
  localparam logic [1:0]  LVL_HIGH      = 2'h3;
endpackage

/* rtl/igpe_prio_if.sv */
// carries per-source requests and levels to the arbiter and the winner back
// assumes both ends sit in the same clock domain
`timescale 1ns/1ps
`default_nettype none
interface igpe_prio_if;
  logic [15:0]      req;
  logic [15:0][1:0] level;
  logic             winValid;
  logic [1:0]       winLevel;
  logic [3:0]       winSource;
  modport producer (output req, output level,
                    input winValid, input winLevel, input winSource);
  modport arbiter  (input req, input level,
                    output winValid, output winLevel, output winSource);
endinterface
`default_nettype wire

/* rtl/igpe_level_arbiter.sv */
// picks the pending request with the highest level, registered winner
// assumes levels and requests are stable, synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module igpe_level_arbiter
  import igpe_pkg::*;
(
  // clock and reset
  input  wire logic   clk,
  input  wire logic   reset_n,
  input  wire logic   ce,
  // sources and winner
  igpe_prio_if.arbiter prio
);
  logic       bestValid;
  logic [1:0] bestLevel;
  logic [3:0] bestSource;

  // ----------------------------------------------------------------
  // search
  // ----------------------------------------------------------------
  // ties go to the lowest source number, so group 2 bit 0 goes first
  always_comb begin
    bestValid  = 1'b0;
    bestLevel  = LVL_OFF;
    bestSource = 4'h0;
    for (int i = 0; i < NUM_SOURCES; i++) begin
      if (prio.req[i] && prio.level[i] > bestLevel) begin // RULE14
        bestValid  = 1'b1;
        bestLevel  = prio.level[i];
        bestSource = 4'(i);
      end
    end
  end

  // ----------------------------------------------------------------
  // winner register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prio.winValid  <= 1'b0;
      prio.winLevel  <= LVL_OFF;
      prio.winSource <= 4'h0;
    end else if (ce) begin
      prio.winValid  <= bestValid;
      prio.winLevel  <= bestLevel;
      prio.winSource <= bestSource;
    end
  end
endmodule
`default_nettype wire

/* rtl/igpe_enables.sv */
// group 2/3 enable and priority registers with source routing
// assumes wishbone classic single cycles and synchronous request levels
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module igpe_enables
  import igpe_pkg::*;
#(
  parameter int ADR_W = 14
)(
  // clock, reset, enable
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             ce,
  // wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [31:0]      wb_dat_i,
  input  wire logic [3:0]       wb_sel_i,
  output var  logic [31:0]      wb_dat_o,
  output var  logic             wb_ack_o,
  // group 2 raw sources
  input  wire logic [7:0]       portA,
  input  wire logic [4:1]       portD,
  input  wire logic             lowVoltageDetect,
  input  wire logic             comparator0,
  input  wire logic             comparator1,
  // group 3 raw sources
  input  wire logic             cipherReq,
  input  wire logic             multichannelTimerReq,
  input  wire logic             serial1ReceiveReq,
  input  wire logic             serial1TransmitReq,
  input  wire logic [3:0]       portC,
  input  wire logic [3:2]       channelReq,
  // routed requests and levels
  output var  logic [7:0]       group2Req,
  output var  logic [7:0]       group3Req,
  output var  logic [31:0]      sourceLevels,
  // presented request
  output var  logic             presentValid,
  output var  logic [1:0]       presentLevel,
  output var  logic [3:0]       presentSource
);
  logic [7:0]  group2EnableHigh_r;
  logic [7:0]  group2EnableLow_r;
  logic [7:0]  group3EnableHigh_r;
  logic [7:0]  group3EnableLow_r;
  logic [7:0]  sourceSelect0_r;
  logic [7:0]  sourceSelect1_r;
  logic [4:1]  padReq;
  logic [3:2]  pccReq;
  logic [7:0]  readData_nxt;
  logic [7:0]  statusByte;
  logic [11:0] wordIndex;
  logic        request;
  logic        writeNow;

  igpe_prio_if prio ();

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign wordIndex = wb_adr_i[13:2];
  assign request   = wb_cyc_i && wb_stb_i;
  // write lands on the edge where the host sees ack, data is held till then
  assign writeNow  = request && wb_ack_o && wb_we_i && wb_sel_i[0];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
    end else if (ce) begin
      wb_ack_o <= request && !wb_ack_o;
    end
  end

  // ----------------------------------------------------------------
  // enable registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      group2EnableHigh_r <= RST_ENABLE;
      group2EnableLow_r  <= RST_ENABLE;
      group3EnableHigh_r <= RST_ENABLE;
      group3EnableLow_r  <= RST_ENABLE;
    end else if (ce && writeNow) begin
      case (wordIndex)
        IDX_G2_EN_HI: group2EnableHigh_r <= wb_dat_i[7:0]; // RULE3
        IDX_G2_EN_LO: group2EnableLow_r  <= wb_dat_i[7:0]; // RULE3
        IDX_G3_EN_HI: group3EnableHigh_r <= wb_dat_i[7:0]; // RULE7
        IDX_G3_EN_LO: group3EnableLow_r  <= wb_dat_i[7:0]; // RULE7
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // source select registers
  // ----------------------------------------------------------------
  // only bits 3..2 of the second select exist, the rest read as zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sourceSelect0_r <= RST_SELECT;
      sourceSelect1_r <= RST_SELECT;
    end else if (ce && writeNow) begin
      case (wordIndex)
        IDX_SRC_SEL0: sourceSelect0_r <= wb_dat_i[7:0];
        IDX_SRC_SEL1: sourceSelect1_r <= wb_dat_i[7:0] & SEL1_RW_MASK;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    statusByte = 8'h00;
    statusByte[STAT_VALID] = presentValid;
    statusByte[STAT_LVL_LSB +: 2] = presentLevel;
    statusByte[3:0] = presentSource;
  end

  always_comb begin
    case (wordIndex)
      IDX_G2_EN_HI: readData_nxt = group2EnableHigh_r;
      IDX_G2_EN_LO: readData_nxt = group2EnableLow_r;
      IDX_G3_EN_HI: readData_nxt = group3EnableHigh_r;
      IDX_G3_EN_LO: readData_nxt = group3EnableLow_r;
      IDX_SRC_SEL0: readData_nxt = sourceSelect0_r;
      IDX_SRC_SEL1: readData_nxt = sourceSelect1_r;
      IDX_STATUS:   readData_nxt = statusByte;
      default:      readData_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_dat_o <= 32'h00000000;
    end else if (ce && request && !wb_ack_o) begin
      wb_dat_o <= {24'h000000, readData_nxt};
    end
  end

  // ----------------------------------------------------------------
  // request routing
  // ----------------------------------------------------------------
  // pins 4..1 and the port C / channel pairs are plain per-bit muxes
  for (genvar b = 1; b <= 4; b++) begin : g_pad
    assign padReq[b] = sourceSelect0_r[b] ? portD[b]
                                          : portA[b]; // RULE11
  end
  for (genvar b = 2; b <= 3; b++) begin : g_pcc
    assign pccReq[b] = sourceSelect1_r[b] ? channelReq[b]
                                          : portC[b]; // RULE13
  end

  // one process owns each routed vector, so no bit has two drivers
  always_comb begin
    group2Req[7] = sourceSelect0_r[7] ? lowVoltageDetect : portA[7]; // RULE12
    group2Req[6] = sourceSelect0_r[6] ? comparator0 : portA[6]; // RULE12
    group2Req[5] = sourceSelect0_r[5] ? comparator1 : portA[5]; // RULE12
    group2Req[4:1] = padReq; // RULE5
    group2Req[0] = portA[0]; // RULE6
    group3Req[7] = cipherReq; // RULE7
    group3Req[6] = multichannelTimerReq; // RULE7
    group3Req[5] = serial1ReceiveReq; // RULE8
    group3Req[4] = serial1TransmitReq; // RULE8
    group3Req[3:2] = pccReq; // RULE9
    group3Req[1:0] = portC[1:0]; // RULE10
  end

  // ----------------------------------------------------------------
  // level decode
  // ----------------------------------------------------------------
  // source k: 0..7 group 2 bit k, 8..15 group 3 bit k-8
  for (genvar k = 0; k < GROUP_BITS; k++) begin : g_lvl
    assign prio.level[k] = {group2EnableHigh_r[k],
                            group2EnableLow_r[k]}; // RULE1 RULE4
    assign prio.level[k+GROUP_BITS] = {group3EnableHigh_r[k],
                                       group3EnableLow_r[k]}; // RULE2
  end
  assign prio.req     = {group3Req, group2Req};
  assign sourceLevels = prio.level;

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  igpe_level_arbiter u_arb (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .prio    (prio)
  );

  assign presentValid  = prio.winValid; // RULE14
  assign presentLevel  = prio.winLevel;
  assign presentSource = prio.winSource;
endmodule
`default_nettype wire

/* sim/igpe_core_model.sv */
// core stand-in that takes whichever request is presented
// assumes the present outputs are registered on clk
`timescale 1ns/1ps
`default_nettype none
module igpe_core_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       presentValid,
  input  wire logic [1:0] presentLevel,
  input  wire logic [3:0] presentSource,
  output var  logic [5:0] taken
);
  // takes one cycle late, like a core finishing its current instruction
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      taken <= 6'h00;
    end else if (presentValid) begin
      taken <= {presentLevel, presentSource};
    end
  end
endmodule
`default_nettype wire

/* sim/igpe_enables_sva.sv */
// assertions on the ports of the group 2/3 priority enable block
// assumes a single clock domain
`timescale 1ns/1ps
`default_nettype none
module igpe_enables_sva (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        ce,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [7:0]  portA,
  input wire logic [3:0]  portC,
  input wire logic        cipherReq,
  input wire logic        multichannelTimerReq,
  input wire logic        serial1ReceiveReq,
  input wire logic        serial1TransmitReq,
  input wire logic [7:0]  group2Req,
  input wire logic [7:0]  group3Req,
  input wire logic [31:0] sourceLevels,
  input wire logic        presentValid,
  input wire logic [1:0]  presentLevel,
  input wire logic [3:0]  presentSource
);
  logic [15:0] rq;
  logic [1:0]  best;
  logic [3:0]  bsrc;
  assign rq = {group3Req, group2Req};
  // strict compare keeps the lowest source on a tie
  always_comb begin
    best = 2'h0;
    bsrc = 4'h0;
    for (int k = 0; k < 16; k++) begin
      if (rq[k] && sourceLevels[2*k+:2] > best) begin
        best = sourceLevels[2*k+:2];
        bsrc = 4'(k);
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_pin0_route: assert property (group2Req[0] == portA[0])
    else $error("pin 0 request not routed");
  a_portc_low: assert property (group3Req[1:0] == portC[1:0])
    else $error("port c low requests not routed");
  a_group3_top: assert property
    (group3Req[7:6] == {cipherReq, multichannelTimerReq})
    else $error("cipher or timer request not routed");
  a_serial_route: assert property
    (group3Req[5:4] == {serial1ReceiveReq, serial1TransmitReq})
    else $error("serial requests not routed");
  a_win_valid: assert property
    (ce |=> presentValid == $past(best != 2'h0))
    else $error("present valid wrong");
  a_win_frozen: assert property
    (!ce |=> $stable(presentValid) && $stable(presentLevel)
      && $stable(presentSource))
    else $error("present outputs moved while clock enable low");
  a_win_level: assert property (ce |=> presentLevel == $past(best))
    else $error("present level not the highest");
  a_win_source: assert property
    (ce && best != 2'h0 |=> presentSource == $past(bsrc))
    else $error("present source wrong");
  a_level_held: assert property
    (!wb_ack_o && !(wb_cyc_i && wb_stb_i) |=> $stable(sourceLevels))
    else $error("levels changed without a bus cycle");
  a_ack_pulse: assert property (ce && wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule
bind igpe_enables igpe_enables_sva igpe_enables_sva_i (.clk, .reset_n, .ce,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .portA, .portC, .cipherReq,
  .multichannelTimerReq, .serial1ReceiveReq, .serial1TransmitReq,
  .group2Req, .group3Req, .sourceLevels, .presentValid, .presentLevel,
  .presentSource);
`default_nettype wire

/* sim/igpe_enables_test.sv */
// self-checking bench for the group 2/3 priority enable block
// assumes a 10 MHz clock and classic wishbone single cycles
`timescale 1ns/1ps
`default_nettype none
module igpe_enables_test
  import igpe_pkg::*;
;
  logic clk = 0, reset_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic ce = 1;
  logic lowVoltageDetect = 0, comparator0 = 0, comparator1 = 0;
  logic cipherReq = 0, multichannelTimerReq = 0;
  logic serial1ReceiveReq = 0, serial1TransmitReq = 0;
  logic [13:0] wb_adr_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, sourceLevels, rd;
  logic [3:0]  wb_sel_i = 0, portC = 0, presentSource;
  logic [7:0]  portA = 0, group2Req, group3Req;
  logic [4:1]  portD = 0;
  logic [3:2]  channelReq = 0;
  logic [1:0]  presentLevel;
  logic [5:0]  taken;
  logic        wb_ack_o, presentValid;
  int err_count = 0, total_checks = 0, cycN = 0, seed = 26000;
  localparam logic [11:0] ADRS [6] = '{IDX_G2_EN_HI, IDX_G2_EN_LO,
    IDX_G3_EN_HI, IDX_G3_EN_LO, IDX_SRC_SEL0, IDX_SRC_SEL1};
  igpe_enables igpe_enables_i (.clk, .reset_n, .ce, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o,
    .wb_ack_o, .portA, .portD, .lowVoltageDetect, .comparator0,
    .comparator1, .cipherReq, .multichannelTimerReq, .serial1ReceiveReq,
    .serial1TransmitReq, .portC, .channelReq, .group2Req, .group3Req,
    .sourceLevels, .presentValid, .presentLevel, .presentSource);
  igpe_core_model igpe_core_model_i (.clk, .reset_n, .presentValid,
    .presentLevel, .presentSource, .taken);
  always #50 clk = ~clk;
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycN++;
    if (cycN > 10000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  // request held until ack is sampled high, then one idle cycle
  // no local limit: only the bench timeout ends a wait
  task automatic wb(input logic w, input logic [11:0] idx,
                    input logic [7:0] d, input logic [3:0] s);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h0, d};
    wb_sel_i <= s;
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [7:0] r2(input logic [7:0] s);
    r2 = {s[7] ? lowVoltageDetect : portA[7], s[6] ? comparator0 : portA[6],
      s[5] ? comparator1 : portA[5],
      (s[4:1] & portD) | (~s[4:1] & portA[4:1]), portA[0]};
  endfunction
  function automatic logic [7:0] r3(input logic [3:2] s);
    r3 = {cipherReq, multichannelTimerReq, serial1ReceiveReq,
      serial1TransmitReq, (s & channelReq) | (~s & portC[3:2]), portC[1:0]};
  endfunction
  function automatic logic [31:0] lvl(input logic [7:0] e [6]);
    for (int k = 0; k < 8; k++) begin
      lvl[2*k+:2] = {e[0][k], e[1][k]};
      lvl[2*k+16+:2] = {e[2][k], e[3][k]};
    end
  endfunction
  function automatic logic [6:0] win(input logic [15:0] q, logic [31:0] l);
    win = 7'h00;
    for (int k = 0; k < 16; k++) begin
      if (q[k] && l[2*k+:2] > win[5:4]) win = {1'b1, l[2*k+:2], 4'(k)};
    end
  endfunction
  initial begin
    logic [7:0] e [6];
    logic [6:0] w;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      wb(1'b0, 12'hfc7 + 12'(i), 8'h00, 4'hf);
      chk("reset value", 32'h0, rd);
    end
    // first pass all levels high, second all off, then random
    for (int it = 0; it < 40; it++) begin
      for (int j = 0; j < 6; j++) begin
        e[j] = it == 0 ? 8'hff : it == 1 ? 8'h00 : 8'($random(seed));
        wb(1'b1, ADRS[j], e[j], 4'h1);
      end
      wb(1'b1, ADRS[it % 4], ~e[it % 4], 4'he);
      {portA, portD, lowVoltageDetect, comparator0, comparator1, cipherReq,
        multichannelTimerReq, serial1ReceiveReq, serial1TransmitReq, portC,
        channelReq} <= it < 2 ? '1 : 25'($random(seed));
      for (int j = 0; j < 6; j++) begin
        wb(1'b0, ADRS[j], 8'h00, 4'hf);
        chk("register", {24'h0, j == 5 ? e[j] & 8'h0c : e[j]}, rd);
      end
      #1;
      chk("group2", {24'h0, r2(e[4])}, {24'h0, group2Req});
      chk("group3", {24'h0, r3(e[5][3:2])}, {24'h0, group3Req});
      chk("levels", lvl(e), sourceLevels);
      w = win({r3(e[5][3:2]), r2(e[4])}, lvl(e));
      chk("present", {25'h0, w}, {25'h0, presentValid, presentLevel,
        presentSource});
      if (w[6]) chk("taken", {26'h0, w[5:0]}, {26'h0, taken});
      wb(1'b0, IDX_STATUS, 8'h00, 4'hf);
      chk("status", {24'h0, w[6], w[5:4], 1'b0, w[3:0]}, rd);
      // clock enable low: new sources must not move the presented winner
      if (it % 8 == 7) begin
        ce <= 1'b0;
        {portA, portD, lowVoltageDetect, comparator0, comparator1, cipherReq,
          multichannelTimerReq, serial1ReceiveReq, serial1TransmitReq, portC,
          channelReq} <= w[6] ? '0 : '1;
        repeat (3) @(posedge clk);
        #1;
        chk("frozen", {25'h0, w}, {25'h0, presentValid, presentLevel,
          presentSource});
        @(posedge clk);
        ce <= 1'b1;
      end
    end
    end_sim();
  end
endmodule
`default_nettype wire
